// ==== src/mpm_core.sv ====
// Program change map, program change output and bulk dump/load engine.
// Assumes a same-clock byte framer on rx/tx and a settings store with a
// one-cycle read latency that holds its read data until the next read.
`timescale 1ns/1ns
`default_nettype none
module mpm_core
#(
    parameter int SET_BYTES = mpm_pkg::SET_BYTES_DEF,
    parameter logic [6:0] SX_MAKER = mpm_pkg::SX_MAKER_DEF
)
(
    input wire logic clk,
    input wire logic rst,
    input wire mpm_pkg::mpm_cfg_t cfg,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic map_wr_en,
    input wire logic [6:0] map_wr_prog,
    input wire logic [6:0] map_wr_patch,
    input wire logic patch_switch,
    input wire logic [6:0] patch_index,
    input wire logic dump_start,
    input wire logic [6:0] dump_first,
    input wire logic [6:0] dump_last,
    input wire logic import_mode,
    input wire logic [6:0] mem_rd_data,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic patch_sel_valid,
    output logic [6:0] patch_sel,
    output logic map_wr_refused,
    output logic mem_rd_en,
    output mpm_pkg::mpm_rd_t mem_rd,
    output logic load_wr_en,
    output mpm_pkg::mpm_load_t load_wr,
    output logic dump_busy,
    output logic load_done,
    output logic load_ok
);
    import mpm_pkg::*;

    initial
    begin
        if (SET_BYTES < 1 || SET_BYTES > 255)
            $error("SET_BYTES out of range");
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    function automatic logic [6:0] fix_map(input logic [6:0] prog);
        fix_map = (prog > LAST_PATCH) ? LAST_PATCH : prog;
    endfunction

    localparam logic [7:0] LAST_IDX = 8'(SET_BYTES - 1);
    localparam logic [7:0] FULL_IDX = 8'(SET_BYTES);

    // ------------------------------------------------------------
    // Program change map
    // ------------------------------------------------------------
    logic [6:0] utab_q [TAB_DEPTH];
    logic rx_rt, rx_stat, rx_dat, chan_ok, pc_hit, utab_wr;
    logic [6:0] user_look, map_look;
    typedef enum {R_IDLE, R_PC, R_MFR, R_ID, R_SET, R_DATA, R_SKIP} mpm_rx_st_t;
    mpm_rx_st_t rst_q, rst_d;

    assign rx_rt = rx_valid && (rx_data >= RT_MIN);
    assign rx_stat = rx_valid && rx_data[7] && !rx_rt;
    assign rx_dat = rx_valid && !rx_data[7];
    assign chan_ok = cfg.omni || (rx_data[3:0] == cfg.rx_chan);
    assign pc_hit = rx_dat && (rst_q == R_PC);
    assign user_look = utab_q[rx_data[6:0]];
    assign map_look = cfg.map_user ? user_look : fix_map(rx_data[6:0]);
    assign utab_wr = map_wr_en && cfg.map_user;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < TAB_DEPTH; i++)
                utab_q[i] <= fix_map(7'(i));
        end
        else if (utab_wr)
        begin
            utab_q[map_wr_prog] <= map_wr_patch;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            patch_sel_valid <= 1'b0;
            patch_sel <= 7'h00;
            map_wr_refused <= 1'b0;
        end
        else
        begin
            patch_sel_valid <= pc_hit;
            patch_sel <= pc_hit ? map_look : patch_sel;
            map_wr_refused <= map_wr_en && !cfg.map_user;
        end
    end

    // ------------------------------------------------------------
    // Receive parser and bulk load
    // ------------------------------------------------------------
    logic [6:0] lset_q;
    logic [7:0] lidx_q;
    logic err_q, got_q, imp_q, imp_fall, sx_mid;

    assign imp_fall = imp_q && !import_mode;
    assign sx_mid = (rst_q == R_MFR) || (rst_q == R_ID) ||
                    (rst_q == R_SET) || (rst_q == R_DATA);

    always_comb
    begin
        rst_d = rst_q;
        if (rx_stat)
        begin
            if (rx_data[7:4] == PC_NIB && chan_ok)
                rst_d = R_PC;
            else if (rx_data == SX_START && import_mode)
                rst_d = R_MFR;
            else
                rst_d = R_IDLE;
        end
        else if (rx_dat)
        begin
            case (rst_q)
                R_MFR: rst_d = (rx_data[6:0] == SX_MAKER) ? R_ID : R_SKIP;
                R_ID: rst_d = (rx_data[6:0] == {2'b00, cfg.device_id}) ?
                              R_SET : R_SKIP;
                R_SET: rst_d = (rx_data[6:0] <= SET_TEMP) ? R_DATA : R_SKIP;
                R_DATA: rst_d = (lidx_q == FULL_IDX) ? R_SKIP : R_DATA;
                default: rst_d = rst_q;
            endcase
        end
        if (!import_mode && sx_mid)
            rst_d = R_IDLE;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rst_q <= R_IDLE;
            lset_q <= 7'h00;
            lidx_q <= 8'h00;
            imp_q <= 1'b0;
            load_wr_en <= 1'b0;
            load_wr <= '0;
        end
        else
        begin
            rst_q <= rst_d;
            imp_q <= import_mode;
            load_wr_en <= rx_dat && (rst_q == R_DATA) && (lidx_q != FULL_IDX);
            if (rx_dat && rst_q == R_SET)
            begin
                lset_q <= rx_data[6:0];
                lidx_q <= 8'h00;
            end
            else if (rx_dat && rst_q == R_DATA && lidx_q != FULL_IDX)
            begin
                load_wr <= '{set: lset_q, idx: lidx_q, data: rx_data[6:0]};
                lidx_q <= lidx_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            err_q <= 1'b0;
            got_q <= 1'b0;
            load_done <= 1'b0;
            load_ok <= 1'b0;
        end
        else
        begin
            if (import_mode && !imp_q)
            begin
                err_q <= 1'b0;
                got_q <= 1'b0;
            end
            else if (rx_stat && rst_q == R_DATA && rx_data == SX_END)
            begin
                got_q <= got_q || (lidx_q == FULL_IDX);
                err_q <= err_q || (lidx_q != FULL_IDX);
            end
            else if ((rx_stat && sx_mid) ||
                     (rx_dat && rst_q == R_SET && rx_data[6:0] > SET_TEMP) ||
                     (rx_dat && rst_q == R_DATA && lidx_q == FULL_IDX))
            begin
                err_q <= 1'b1;
            end
            load_done <= imp_fall;
            if (imp_fall)
                load_ok <= got_q && !err_q && !sx_mid;
        end
    end

    // ------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------
    typedef enum {T_IDLE, T_PCS, T_PCN, T_F0, T_MFR, T_ID, T_SET, T_RD,
                  T_WAIT, T_DATA, T_EOX} mpm_tx_st_t;
    mpm_tx_st_t tst_q, tst_d;
    logic pc_pend_q, push_valid, push_go, in_ready, dump_ok;
    logic [6:0] pc_num_q, cur_set_q, last_set_q;
    logic [7:0] idx_q, push_byte;
    logic [3:0] tx_chan_eff;

    assign tx_chan_eff = cfg.tx_follow_rx ? cfg.rx_chan : cfg.tx_chan;
    assign dump_ok = dump_start && (dump_first <= dump_last) &&
                     (dump_last <= SET_TEMP);
    assign push_valid = (tst_q != T_IDLE) && (tst_q != T_RD) &&
                        (tst_q != T_WAIT);
    assign push_go = push_valid && in_ready;

    always_comb
    begin
        case (tst_q)
            T_PCS: push_byte = {PC_NIB, tx_chan_eff};
            T_PCN: push_byte = {1'b0, pc_num_q};
            T_F0: push_byte = SX_START;
            T_MFR: push_byte = {1'b0, SX_MAKER};
            T_ID: push_byte = {3'b000, cfg.device_id};
            T_SET: push_byte = {1'b0, cur_set_q};
            T_DATA: push_byte = {1'b0, mem_rd_data};
            T_EOX: push_byte = SX_END;
            default: push_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        tst_d = tst_q;
        case (tst_q)
            T_IDLE:
                if (dump_ok)
                    tst_d = T_F0;
                else if (pc_pend_q)
                    tst_d = T_PCS;
            T_PCS: tst_d = push_go ? T_PCN : T_PCS;
            T_PCN: tst_d = push_go ? T_IDLE : T_PCN;
            T_F0: tst_d = push_go ? T_MFR : T_F0;
            T_MFR: tst_d = push_go ? T_ID : T_MFR;
            T_ID: tst_d = push_go ? T_SET : T_ID;
            T_SET: tst_d = push_go ? T_RD : T_SET;
            T_RD: tst_d = T_WAIT;
            T_WAIT: tst_d = T_DATA;
            T_DATA:
                if (push_go)
                    tst_d = (idx_q == LAST_IDX) ? T_EOX : T_RD;
            T_EOX:
                if (push_go)
                    tst_d = (cur_set_q == last_set_q) ? T_IDLE : T_F0;
            default: tst_d = T_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tst_q <= T_IDLE;
            pc_pend_q <= 1'b0;
            pc_num_q <= 7'h00;
            cur_set_q <= 7'h00;
            last_set_q <= 7'h00;
            idx_q <= 8'h00;
            dump_busy <= 1'b0;
        end
        else
        begin
            tst_q <= tst_d;
            if (patch_switch && cfg.program_change_output_enable)
            begin
                pc_pend_q <= 1'b1;
                pc_num_q <= patch_index;
            end
            else if (tst_q == T_PCN && push_go)
            begin
                pc_pend_q <= 1'b0;
            end
            if (tst_q == T_IDLE && dump_ok)
            begin
                cur_set_q <= dump_first;
                last_set_q <= dump_last;
            end
            else if (tst_q == T_EOX && push_go)
            begin
                cur_set_q <= cur_set_q + 7'h01;
            end
            if (tst_q == T_SET)
                idx_q <= 8'h00;
            else if (tst_q == T_DATA && push_go)
                idx_q <= idx_q + 8'h01;
            dump_busy <= (tst_d != T_IDLE) && (tst_d != T_PCS) &&
                         (tst_d != T_PCN);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_rd_en <= 1'b0;
            mem_rd <= '0;
        end
        else
        begin
            mem_rd_en <= (tst_q == T_RD);
            if (tst_q == T_RD)
                mem_rd <= '{live: (cur_set_q == SET_TEMP),
                            set: cur_set_q, idx: idx_q};
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    logic [7:0] tail_q, head_d, tail_d;
    logic tail_v_q, head_v_d, tail_v_d, pop;

    assign in_ready = !tail_v_q;
    assign pop = tx_valid && tx_ready;

    always_comb
    begin
        head_d = tx_data;
        head_v_d = tx_valid;
        tail_d = tail_q;
        tail_v_d = tail_v_q;
        if (pop && tail_v_q)
        begin
            head_d = tail_q;
            tail_d = push_byte;
            tail_v_d = push_go;
        end
        else if (pop || !tx_valid)
        begin
            head_d = push_byte;
            head_v_d = push_go;
        end
        else if (push_go)
        begin
            tail_d = push_byte;
            tail_v_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            tail_q <= 8'h00;
            tail_v_q <= 1'b0;
        end
        else
        begin
            tx_data <= head_d;
            tx_valid <= head_v_d;
            tail_q <= tail_d;
            tail_v_q <= tail_v_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_imp_exit;
        imp_q && !import_mode;
    endsequence

    AST_FIX_TOP: assert property (pc_hit && !cfg.map_user &&
        rx_data[6:0] > LAST_PATCH |=> patch_sel_valid && patch_sel == 7'h77)
        else $error("high program not mapped to last preset");
    AST_FIX_MAP: assert property (pc_hit && !cfg.map_user &&
        rx_data[6:0] == PROGS_PER_AREA |=> patch_sel == 7'h28)
        else $error("fixed map order wrong");
    AST_USER_MAP: assert property (pc_hit && cfg.map_user
        |=> patch_sel == $past(user_look))
        else $error("user map not used");
    AST_WR_BLOCK: assert property (map_wr_en && !cfg.map_user |=>
        utab_q[$past(map_wr_prog)] == $past(utab_q[map_wr_prog]))
        else $error("user table written with fixed source");
    AST_PC_NUM: assert property (push_go && tst_q == T_PCN
        |-> push_byte[6:0] == pc_num_q && tst_d == T_IDLE)
        else $error("program number byte wrong");
    AST_RX_CHAN: assert property (rx_stat && rx_data[7:4] == PC_NIB &&
        !cfg.omni && rx_data[3:0] != cfg.rx_chan |=> rst_q != R_PC)
        else $error("foreign channel accepted");
    AST_SX_ID: assert property (import_mode && rx_dat && rst_q == R_ID &&
        rx_data[6:0] != {2'b00, cfg.device_id} |=> rst_q == R_SKIP)
        else $error("foreign identifier accepted");
    AST_LIVE: assert property (mem_rd_en && mem_rd.set == SET_TEMP
        |-> mem_rd.live)
        else $error("live set not read from live buffer");
    AST_PC_OFF: assert property (tst_q == T_IDLE && !pc_pend_q &&
        !dump_ok && !(patch_switch && cfg.program_change_output_enable)
        |=> tst_q == T_IDLE)
        else $error("program change sent while disabled");
    AST_VERIFY: assert property (s_imp_exit |=> load_done ##1 !load_done)
        else $error("import exit not verified");
    AST_NO_LOSS: assert property (tail_v_q && !tx_ready
        |=> tail_v_q && $stable(tail_q) && $stable(tx_data))
        else $error("buffered byte lost under stall");
endmodule
`default_nettype wire

// ==== src/mpm_pkg.sv ====
// Constants, field layouts and carriers for the program map and bulk block.
// Assumes byte streams from a same-clock serial framer on both sides.
package mpm_pkg;
    // ------------------------------------------------------------
    // Message bytes
    // ------------------------------------------------------------
    localparam logic [3:0] PC_NIB = 4'hC;
    localparam logic [7:0] SX_START = 8'hF0;
    localparam logic [7:0] SX_END = 8'hF7;
    localparam logic [7:0] RT_MIN = 8'hF8;
    // Exclusive maker byte, value arbitrary
    localparam logic [6:0] SX_MAKER_DEF = 7'h7D;
    // ------------------------------------------------------------
    // Patch order and data sets
    // ------------------------------------------------------------
    localparam logic [6:0] PROGS_PER_AREA = 7'h28;
    localparam logic [6:0] LAST_PATCH = 7'h77;
    localparam logic [6:0] SET_SYSTEM = 7'h00;
    localparam logic [6:0] SET_USER_LAST = 7'h50;
    localparam logic [6:0] SET_TEMP = 7'h51;
    localparam int TAB_DEPTH = 128;
    localparam int SET_BYTES_DEF = 16;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rx_chan;
        logic [3:0] tx_chan;
        logic omni;
        logic tx_follow_rx;
        logic [4:0] device_id;
        logic program_change_output_enable;
        logic map_user;
    } mpm_cfg_t;
    typedef struct packed {
        logic live;
        logic [6:0] set;
        logic [7:0] idx;
    } mpm_rd_t;
    typedef struct packed {
        logic [6:0] set;
        logic [7:0] idx;
        logic [6:0] data;
    } mpm_load_t;
endpackage

// ==== bench/mpm_far.sv ====
// Far-side model: settings store behind the export reads, output byte sink.
// Assumes the core's one-cycle store read and valid/ready output stream.
`timescale 1ns/1ns
`default_nettype none
module mpm_far
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_rd_en,
    input wire mpm_pkg::mpm_rd_t mem_rd,
    output logic [6:0] mem_rd_data,
    output logic tx_ready
);
    import mpm_pkg::*;
    // ------------------------------------------------------------
    // Store read and sink readiness
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_rd_data <= 7'h00;
            tx_ready <= 1'b0;
        end
        else
        begin
            if (mem_rd_en)
                mem_rd_data <= mem_rd.set + 7'(mem_rd.idx * 5)
                    + (mem_rd.live ? 7'h33 : 7'h00);
            // Listening before any export, stalls when slow
            tx_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the program map and bulk core.
// Assumes the far-side model answers store reads and sinks output bytes.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mpm_pkg::*;
    localparam int NB = 16;
    logic clk, rst, slow;
    mpm_cfg_t cfg;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, map_wr_en, patch_switch, dump_start, import_mode;
    logic [6:0] map_wr_prog, map_wr_patch, patch_index, dump_first;
    logic [6:0] dump_last, mem_rd_data, patch_sel;
    logic tx_ready, tx_valid, patch_sel_valid, map_wr_refused, mem_rd_en;
    logic load_wr_en, dump_busy, load_done, load_ok;
    mpm_rd_t mem_rd;
    mpm_load_t load_wr;
    logic [7:0] q_tx[$];
    logic [6:0] q_sel[$];
    mpm_load_t q_ld[$];
    logic q_ok[$];
    logic q_ref[$];
    logic [6:0] utab[128];
    int n_fail, check_count;

    mpm_core #(.SET_BYTES(NB), .SX_MAKER(SX_MAKER_DEF)) dut (.clk(clk),
        .rst(rst), .cfg(cfg), .rx_data(rx_data), .rx_valid(rx_valid),
        .map_wr_en(map_wr_en), .map_wr_prog(map_wr_prog),
        .map_wr_patch(map_wr_patch), .patch_switch(patch_switch),
        .patch_index(patch_index), .dump_start(dump_start),
        .dump_first(dump_first), .dump_last(dump_last),
        .import_mode(import_mode), .mem_rd_data(mem_rd_data),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .patch_sel_valid(patch_sel_valid), .patch_sel(patch_sel),
        .map_wr_refused(map_wr_refused), .mem_rd_en(mem_rd_en),
        .mem_rd(mem_rd), .load_wr_en(load_wr_en), .load_wr(load_wr),
        .dump_busy(dump_busy), .load_done(load_done), .load_ok(load_ok));
    mpm_far far (.clk(clk), .rst(rst), .slow(slow), .mem_rd_en(mem_rd_en),
        .mem_rd(mem_rd), .mem_rd_data(mem_rd_data), .tx_ready(tx_ready));

    // ------------------------------------------------------------
    // Reference values and comparisons
    // ------------------------------------------------------------
    function automatic logic [6:0] fixmap(logic [6:0] p);
        return (p > LAST_PATCH) ? LAST_PATCH : p;
    endfunction
    function automatic logic [6:0] sdat(logic [6:0] s, logic [7:0] i);
        return s + 7'(i * 5) + ((s == SET_TEMP) ? 7'h33 : 7'h00);
    endfunction
    task automatic report(string what, logic [22:0] e, logic [22:0] g);
        check_count++;
        if (e !== g)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_tx(logic [7:0] g);
        report("tx byte", q_tx.size() > 0 ? 23'(q_tx.pop_front()) : '1,
            23'(g));
    endtask
    task automatic chk_sel(logic [6:0] g);
        report("patch", q_sel.size() > 0 ? 23'(q_sel.pop_front()) : '1, 23'(g));
    endtask
    task automatic chk_ld(mpm_load_t g);
        report("load", q_ld.size() > 0 ? 23'(q_ld.pop_front()) : '1, 23'(g));
    endtask
    task automatic chk_flag(string what, logic g);
        if (what == "refused")
            report(what, q_ref.size() > 0 ? 23'(q_ref.pop_front()) : '1, 23'(g));
        else
            report(what, q_ok.size() > 0 ? 23'(q_ok.pop_front()) : '1, 23'(g));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst && tx_valid && tx_ready) chk_tx(tx_data);
        if (!rst && tx_valid && tx_ready && tx_data == SX_START)
            report("busy", 23'h1, 23'(dump_busy));
        if (!rst && patch_sel_valid) chk_sel(patch_sel);
        if (!rst && load_wr_en) chk_ld(load_wr);
        if (!rst && map_wr_refused) chk_flag("refused", 1'b1);
        if (!rst && load_done) chk_flag("load ok", load_ok);
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic idle();
        int k;
        k = 0;
        while ((q_tx.size() + q_sel.size() + q_ld.size() + q_ok.size()
            + q_ref.size() != 0 || dump_busy !== 1'b0) && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 3000) report("drain", 23'h0, 23'h1);
        repeat (12) @(posedge clk);
    endtask
    task automatic rx(logic [7:0] b);
        @(posedge clk);
        rx_data <= b;
        rx_valid <= 1'b1;
    endtask
    task automatic rx_end();
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    task automatic prog(logic [3:0] ch, logic [6:0] p, bit take);
        if (take) q_sel.push_back(cfg.map_user ? utab[p] : fixmap(p));
        rx({PC_NIB, ch});
        rx({1'b0, p});
        rx_end();
    endtask
    task automatic map_wr(logic [6:0] p, logic [6:0] pat);
        if (!cfg.map_user) q_ref.push_back(1'b1);
        else utab[p] = pat;
        @(posedge clk);
        map_wr_en <= 1'b1;
        map_wr_prog <= p;
        map_wr_patch <= pat;
        @(posedge clk);
        map_wr_en <= 1'b0;
    endtask
    task automatic sw(logic [6:0] idx);
        logic [3:0] ch;
        ch = cfg.tx_follow_rx ? cfg.rx_chan : cfg.tx_chan;
        if (cfg.program_change_output_enable)
        begin
            q_tx.push_back({PC_NIB, ch});
            q_tx.push_back({1'b0, idx});
        end
        @(posedge clk);
        patch_switch <= 1'b1;
        patch_index <= idx;
        @(posedge clk);
        patch_switch <= 1'b0;
        idle();
    endtask
    task automatic dump(logic [6:0] f, logic [6:0] l);
        for (int s = f; s <= l; s++)
        begin
            q_tx.push_back(SX_START);
            q_tx.push_back({1'b0, SX_MAKER_DEF});
            q_tx.push_back({3'h0, cfg.device_id});
            q_tx.push_back(8'(s));
            for (int i = 0; i < NB; i++)
                q_tx.push_back({1'b0, sdat(7'(s), 8'(i))});
            q_tx.push_back(SX_END);
        end
        @(posedge clk);
        dump_start <= 1'b1;
        dump_first <= f;
        dump_last <= l;
        @(posedge clk);
        dump_start <= 1'b0;
        idle();
    endtask
    task automatic frame(logic [4:0] id, logic [6:0] set, int n);
        logic [6:0] d;
        rx(SX_START);
        rx({1'b0, SX_MAKER_DEF});
        rx({3'h0, id});
        rx({1'b0, set});
        rx(RT_MIN);
        for (int i = 0; i < n; i++)
        begin
            d = 7'($urandom);
            if (id == cfg.device_id) q_ld.push_back({set, 8'(i), d});
            rx({1'b0, d});
        end
        rx(SX_END);
        rx_end();
    endtask
    task automatic imp_exit(logic ok);
        q_ok.push_back(ok);
        @(posedge clk);
        import_mode <= 1'b0;
        idle();
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #500000;
        report("watchdog", 23'h0, 23'h1);
        conclude();
    end
    initial
    begin
        void'($urandom(1));
        n_fail = 0;
        check_count = 0;
        for (int p = 0; p < 128; p++) utab[p] = fixmap(7'(p));
        rst = 1'b1;
        slow = 1'b0;
        cfg = '{4'h3, 4'h9, 1'b0, 1'b0, 5'($urandom), 1'b1, 1'b0};
        rx_data = 8'h00;
        rx_valid = 1'b0;
        map_wr_en = 1'b0;
        map_wr_prog = 7'h00;
        map_wr_patch = 7'h00;
        patch_switch = 1'b0;
        patch_index = 7'h00;
        dump_start = 1'b0;
        dump_first = 7'h00;
        dump_last = 7'h00;
        import_mode = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (utab[p])
            if (p % 8 == 7 || p == 40 || p == 80)
                prog(4'h3, 7'(p), 1);
        prog(4'h5, 7'($urandom), 0);
        cfg.omni <= 1'b1;
        prog(4'h5, 7'($urandom), 1);
        idle();
        map_wr(7'h05, 7'h64);
        prog(4'h3, 7'h05, 1);
        cfg.map_user <= 1'b1;
        idle();
        map_wr(7'h05, 7'h64);
        repeat (4) map_wr(7'($urandom), 7'($urandom_range(119)));
        prog(4'h3, 7'h05, 1);
        prog(4'h3, 7'($urandom), 1);
        cfg.map_user <= 1'b0;
        idle();
        prog(4'h3, 7'h05, 1);
        sw(7'h00);
        sw(LAST_PATCH);
        cfg.tx_follow_rx <= 1'b1;
        slow <= 1'b1;
        idle();
        sw(7'($urandom_range(119)));
        cfg.program_change_output_enable <= 1'b0;
        idle();
        sw(7'h11);
        dump(SET_SYSTEM, 7'h02);
        slow <= 1'b0;
        dump(SET_USER_LAST, SET_TEMP);
        dump(7'h05, 7'h03);
        import_mode <= 1'b1;
        frame(cfg.device_id, 7'h01, NB);
        frame(cfg.device_id + 5'h1, 7'h02, NB);
        frame(cfg.device_id, SET_TEMP, NB);
        imp_exit(1'b1);
        import_mode <= 1'b1;
        frame(cfg.device_id, 7'h03, 8);
        imp_exit(1'b0);
        conclude();
    end
endmodule
`default_nettype wire
